// *** include/rmf_pkg.sv ***
// Constants, register map and carrier types of the metering and fault recorder.
//
// What this block does
// RULE_01: Residual voltage is the phasor sum of three phase voltages unless external VT.
// RULE_02: Positive sequence voltage is computed from phase voltages and metered.
// RULE_03: Frequency reference is line 2-1 alone, or positive sequence when 3-2 present.
// RULE_04: Frequency is suppressed when its reference is under 40 percent of rated.
// RULE_05: Frequency is suppressed outside 45-55 Hz (50 Hz) or 55-65 Hz (60 Hz).
// RULE_06: A temperature channel above 205 degrees is flagged disconnected.
// RULE_07: A temperature channel below minus 35 degrees is flagged shorted.
// RULE_08: A faulty temperature channel shows a blank value instead of a reading.
// RULE_09: Any temperature sensor fault raises the maintenance alarm.
// RULE_10: After trip, hold maximum RMS of three phase and residual currents for 30 ms.
// RULE_11: Captured trip currents live in volatile flip-flops only.
// RULE_12: Unbalance is negative sequence over base current, percent, range 10 to 500.
// RULE_13: Two-phase negative sequence is |I1 - a2 I3| over root three.
// RULE_14: Each record spans 86 periods, a settable number (default 36) before trigger.
// RULE_15: The recorder stores 12 samples per period per analog signal.
// RULE_16: At most two records are kept, the oldest overwritten by a new one.
// RULE_17: A record holds four analog channels, ten inputs, trip output and pick-up.
// RULE_18: Each record carries samples, the event date and a channel description.
// RULE_19: The frequency threshold uses the rated line voltage from configuration.
// RULE_20: Suppressed frequency reads as zero with an explicit invalid flag.
// RULE_21: The 30 ms capture starts on each trip rising edge, afresh every time.
package rmf_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RATED_V = 8'h04;
	localparam logic [7:0] OFS_BASE_I = 8'h08;
	localparam logic [7:0] OFS_PRETRIG = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_FREQ = 8'h14;
	localparam logic [7:0] OFS_RESID_V = 8'h18;
	localparam logic [7:0] OFS_POSSEQ_V = 8'h1C;
	localparam logic [7:0] OFS_UNBAL = 8'h20;
	localparam logic [7:0] OFS_TRIP_I1 = 8'h24;
	localparam logic [7:0] OFS_TRIP_I2 = 8'h28;
	localparam logic [7:0] OFS_TRIP_I3 = 8'h2C;
	localparam logic [7:0] OFS_TRIP_I0 = 8'h30;
	localparam logic [7:0] OFS_TEMP_FAULT = 8'h34;
	localparam logic [7:0] OFS_REC_SEL = 8'h38;
	localparam logic [7:0] OFS_REC_ANA01 = 8'h3C;
	localparam logic [7:0] OFS_REC_ANA23 = 8'h40;
	localparam logic [7:0] OFS_REC_DIG = 8'h44;
	localparam logic [7:0] OFS_REC_DATE = 8'h48;
	localparam logic [7:0] OFS_REC_INFO = 8'h4C;
	localparam logic [7:0] OFS_TEMP01 = 8'h50;

	// Control register field positions.
	localparam int CTRL_EXT_VT = 0;
	localparam int CTRL_U32_PRESENT = 1;
	localparam int CTRL_RATED_60HZ = 2;
	localparam int CTRL_TWO_PHASE = 3;
	localparam int CTRL_REC_VOLTAGE = 4;

	// Reset values.
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [15:0] RATED_V_RESET = 16'h2710;
	localparam logic [15:0] BASE_I_RESET = 16'h03E8;
	localparam logic [6:0] PRETRIG_RESET = 7'h24;

	// Frequency checks, frequency in units of 0.01 Hz.
	localparam logic [15:0] F50_LOW = 16'h1194;
	localparam logic [15:0] F50_HIGH = 16'h157C;
	localparam logic [15:0] F60_HIGH = 16'h1964;
	localparam logic [6:0] FREQ_MIN_PCT = 7'h28;

	// Temperature limits in whole degrees and the blank display code.
	localparam logic signed [15:0] TEMP_OPEN_LIMIT = 16'sh00CD;
	localparam logic signed [15:0] TEMP_SHORT_LIMIT = -16'sh0023;
	localparam logic [15:0] TEMP_BLANK = 16'h8000;
	localparam int TEMP_CHANNELS = 8;

	// Unbalance range in percent.
	localparam logic [23:0] UNBAL_MIN = 24'h00_000A;
	localparam logic [23:0] UNBAL_MAX = 24'h00_01F4;

	// Q15 constants for sequence arithmetic.
	localparam logic signed [17:0] Q_HALF = 18'sh0_4000;
	localparam logic signed [17:0] Q_SQRT3_HALF = 18'sh0_6EDA;
	localparam logic signed [17:0] Q_THIRD = 18'sh0_2AAB;
	localparam logic signed [17:0] Q_INV_SQRT3 = 18'sh0_49E7;
	localparam logic [17:0] Q_SQRT3 = 18'h0_DDB4;

	// Recorder geometry.
	localparam int REC_PERIODS = 86;
	localparam int SAMPLES_PER_PERIOD = 12;
	localparam int REC_DEPTH = REC_PERIODS * SAMPLES_PER_PERIOD;
	localparam int REC_SLOTS = 2;

	// Timing of the trip current window.
	localparam int CLK_PERIOD_NS = 50;
	localparam int TRIP_WINDOW_MS = 30;
	localparam int TRIP_WINDOW_CYCLES = (TRIP_WINDOW_MS * 1000000) / CLK_PERIOD_NS;

	// A fundamental phasor in signed fixed point.
	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} rmf_phasor_t;

	// One recorder sample: four analog words, ten inputs, trip output and pick-up.
	typedef struct packed {
		logic [3:0][15:0] ana;
		logic [9:0] din;
		logic trip;
		logic pickup;
	} rmf_sample_t;

	// Recorder state machine.
	typedef enum logic [0:0] {
		REC_FILL = 1'b0,
		REC_POST = 1'b1
	} rmf_rec_state_t;

	// Divider state machine.
	typedef enum logic [0:0] {
		DIV_IDLE = 1'b0,
		DIV_RUN = 1'b1
	} rmf_div_state_t;
endpackage

// *** rtl/rmf_top.sv ***
// Metering, trip current capture and two-slot disturbance recorder behind APB registers.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module rmf_top #(
	parameter int TRIP_WINDOW_CYCLES = rmf_pkg::TRIP_WINDOW_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fundamental phasors and external residual voltage.
	input wire rmf_pkg::rmf_phasor_t volt_phase [3],
	input wire rmf_pkg::rmf_phasor_t curr_phase [3],
	input wire rmf_pkg::rmf_phasor_t residual_voltage_ext,
	// Fundamental RMS magnitudes and the measured frequency.
	input wire logic [15:0] line_voltage_2_1,
	input wire logic [15:0] curr_rms [3],
	input wire logic [15:0] residual_current,
	input wire logic [15:0] freq_measured,
	// Temperature sensor channels in whole degrees.
	input wire logic signed [15:0] temp_in [rmf_pkg::TEMP_CHANNELS],
	// Recorder sources.
	input wire logic sample_tick,
	input wire logic [3:0][15:0] inst_current,
	input wire logic [3:0][15:0] inst_voltage,
	input wire logic [9:0] digital_in,
	input wire logic pickup,
	input wire logic trip_output,
	input wire logic rec_trigger,
	input wire logic [31:0] date_stamp,
	// Status outputs.
	output logic freq_valid,
	output logic maintenance_alarm
);
	localparam int DEPTH = rmf_pkg::REC_DEPTH;

	// Software registers.
	logic [4:0] ctrl;
	logic [15:0] rated_line_voltage;
	logic [15:0] base_current;
	logic [6:0] pretrig;
	logic [15:0] rec_sel_index;
	logic rec_sel_slot;

	// Metering results.
	rmf_pkg::rmf_phasor_t residual_voltage;
	logic [15:0] positive_sequence_voltage;
	logic [15:0] negative_sequence_current;
	logic [15:0] freq_value;
	logic [23:0] unbalance;
	localparam int TEMP_CH = rmf_pkg::TEMP_CHANNELS;
	logic [TEMP_CH-1:0] temp_open;
	logic [TEMP_CH-1:0] temp_short;
	logic [15:0] temp_display [TEMP_CH];
	logic [15:0] temp_hold [TEMP_CH];

	// Trip capture.
	logic trip_prev;
	logic [31:0] trip_timer;
	logic [15:0] trip_current_phase1, trip_current_phase2, trip_current_phase3, trip_current_residual;

	// Alpha-max beta-min magnitude of a phasor; within a few percent of the true modulus.
	function automatic logic [15:0] mag(input logic signed [17:0] re, input logic signed [17:0] im);
		logic [17:0] ar, ai;
		logic [18:0] sum;
		ar = re[17] ? 18'(-re) : 18'(re);
		ai = im[17] ? 18'(-im) : 18'(im);
		sum = (ar > ai) ? 19'(ar) + 19'((ai * 3) >> 3) : 19'(ai) + 19'((ar * 3) >> 3);
		mag = (sum > 19'h0_FFFF) ? 16'hFFFF : sum[15:0];
	endfunction

	// Q15 multiply of a signed value by a signed constant.
	function automatic logic signed [17:0] qmul(input logic signed [17:0] x, input logic signed [17:0] k);
		logic signed [35:0] p;
		p = x * k;
		qmul = 18'(p >>> 15);
	endfunction

	// Phasor rotation by +120 degrees (a) or -120 degrees (a squared).
	function automatic logic [35:0] rot(input logic signed [17:0] x, input logic signed [17:0] y, input logic neg);
		logic signed [17:0] hx, hy, sx, sy;
		hx = qmul(x, rmf_pkg::Q_HALF);
		hy = qmul(y, rmf_pkg::Q_HALF);
		sx = qmul(x, rmf_pkg::Q_SQRT3_HALF);
		sy = qmul(y, rmf_pkg::Q_SQRT3_HALF);
		rot = neg ? {18'(-hx + sy), 18'(-sx - hy)} : {18'(-hx - sy), 18'(sx - hy)};
	endfunction

	// Sequence phasors, recomputed combinationally from the current inputs.
	logic signed [17:0] v_re [3], v_im [3], i_re [3], i_im [3];
	logic [35:0] v2a, v3a2, i2a2, i3a, i3a2;
	logic signed [17:0] pos_re, pos_im, neg_re, neg_im;
	logic [15:0] pos_line;
	always_comb
	begin
		for (int k = 0; k < 3; k++)
		begin
			v_re[k] = 18'(volt_phase[k].re);
			v_im[k] = 18'(volt_phase[k].im);
			i_re[k] = 18'(curr_phase[k].re);
			i_im[k] = 18'(curr_phase[k].im);
		end
		v2a = rot(v_re[1], v_im[1], 1'b0);
		v3a2 = rot(v_re[2], v_im[2], 1'b1);
		i2a2 = rot(i_re[1], i_im[1], 1'b1);
		i3a = rot(i_re[2], i_im[2], 1'b0);
		i3a2 = rot(i_re[2], i_im[2], 1'b1);
		pos_re = qmul(18'(v_re[0] + $signed(v2a[35:18]) + $signed(v3a2[35:18])), rmf_pkg::Q_THIRD); // RULE_02
		pos_im = qmul(18'(v_im[0] + $signed(v2a[17:0]) + $signed(v3a2[17:0])), rmf_pkg::Q_THIRD);
		if (ctrl[rmf_pkg::CTRL_TWO_PHASE])
		begin
			neg_re = qmul(18'(i_re[0] - $signed(i3a2[35:18])), rmf_pkg::Q_INV_SQRT3); // RULE_13
			neg_im = qmul(18'(i_im[0] - $signed(i3a2[17:0])), rmf_pkg::Q_INV_SQRT3);
		end
		else
		begin
			neg_re = qmul(18'(i_re[0] + $signed(i2a2[35:18]) + $signed(i3a[35:18])), rmf_pkg::Q_THIRD);
			neg_im = qmul(18'(i_im[0] + $signed(i2a2[17:0]) + $signed(i3a[17:0])), rmf_pkg::Q_THIRD);
		end
		// Phase quantity scaled by root three so it compares with a line voltage rating.
		pos_line = 16'((34'(positive_sequence_voltage) * 34'(rmf_pkg::Q_SQRT3)) >> 15);
	end

	// Residual voltage, positive sequence voltage and negative sequence current registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			residual_voltage <= '0;
			positive_sequence_voltage <= 16'h0000;
			negative_sequence_current <= 16'h0000;
		end
		else
		begin
			if (ctrl[rmf_pkg::CTRL_EXT_VT])
				residual_voltage <= residual_voltage_ext;
			else
			begin
				residual_voltage.re <= 16'(v_re[0] + v_re[1] + v_re[2]); // RULE_01
				residual_voltage.im <= 16'(v_im[0] + v_im[1] + v_im[2]);
			end
			positive_sequence_voltage <= mag(pos_re, pos_im); // RULE_02
			negative_sequence_current <= mag(neg_re, neg_im);
		end
	end

	// Frequency validation; a suppressed reading shows as zero with the valid flag low.
	logic [15:0] freq_ref;
	logic ref_ok;
	logic range_ok;
	always_comb
	begin
		freq_ref = ctrl[rmf_pkg::CTRL_U32_PRESENT] ? pos_line : line_voltage_2_1; // RULE_03
		ref_ok = (23'(freq_ref) * 23'd100) >= (23'(rated_line_voltage) * 23'(rmf_pkg::FREQ_MIN_PCT)); // RULE_04 RULE_19
		if (ctrl[rmf_pkg::CTRL_RATED_60HZ])
			range_ok = (freq_measured >= rmf_pkg::F50_HIGH) && (freq_measured <= rmf_pkg::F60_HIGH);
		else
			range_ok = (freq_measured >= rmf_pkg::F50_LOW) && (freq_measured <= rmf_pkg::F50_HIGH); // RULE_05
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			freq_valid <= 1'b0;
			freq_value <= 16'h0000;
		end
		else
		begin
			freq_valid <= ref_ok && range_ok;
			freq_value <= (ref_ok && range_ok) ? freq_measured : 16'h0000; // RULE_20
		end
	end

	// Temperature supervision; each reading is held a cycle to line up with its fault flags.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			temp_open <= '0;
			temp_short <= '0;
			maintenance_alarm <= 1'b0;
			for (int k = 0; k < TEMP_CH; k++)
			begin
				temp_display[k] <= rmf_pkg::TEMP_BLANK;
				temp_hold[k] <= 16'h0000;
			end
		end
		else
		begin
			for (int k = 0; k < TEMP_CH; k++)
			begin
				temp_open[k] <= temp_in[k] > rmf_pkg::TEMP_OPEN_LIMIT; // RULE_06
				temp_short[k] <= temp_in[k] < rmf_pkg::TEMP_SHORT_LIMIT; // RULE_07
				temp_hold[k] <= temp_in[k];
				temp_display[k] <= (temp_open[k] || temp_short[k]) ? rmf_pkg::TEMP_BLANK : temp_hold[k]; // RULE_08
			end
			maintenance_alarm <= |{temp_open, temp_short}; // RULE_09
		end
	end

	// Trip current capture: window restarts on every trip rising edge, values are plain flip-flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip_prev <= 1'b0;
			trip_timer <= 32'h0000_0000;
			trip_current_phase1 <= 16'h0000; // RULE_11
			trip_current_phase2 <= 16'h0000;
			trip_current_phase3 <= 16'h0000;
			trip_current_residual <= 16'h0000;
		end
		else
		begin
			trip_prev <= trip_output;
			if (trip_output && !trip_prev)
			begin
				trip_timer <= 32'(TRIP_WINDOW_CYCLES); // RULE_21
				trip_current_phase1 <= curr_rms[0];
				trip_current_phase2 <= curr_rms[1];
				trip_current_phase3 <= curr_rms[2];
				trip_current_residual <= residual_current;
			end
			else if (trip_timer != 32'h0000_0000)
			begin
				trip_timer <= trip_timer - 32'h0000_0001;
				if (curr_rms[0] > trip_current_phase1)
					trip_current_phase1 <= curr_rms[0]; // RULE_10
				if (curr_rms[1] > trip_current_phase2)
					trip_current_phase2 <= curr_rms[1];
				if (curr_rms[2] > trip_current_phase3)
					trip_current_phase3 <= curr_rms[2];
				if (residual_current > trip_current_residual)
					trip_current_residual <= residual_current;
			end
		end
	end

	// Unbalance: a slow restoring divider suffices for a value refreshed every 25 cycles.
	rmf_pkg::rmf_div_state_t div_state;
	logic [23:0] div_num;
	logic [16:0] div_rem;
	logic [23:0] div_quot;
	logic [4:0] div_cnt;
	logic [16:0] div_try;
	assign div_try = {div_rem[15:0], div_num[23]} - {1'b0, base_current};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_state <= rmf_pkg::DIV_IDLE;
			div_num <= 24'h00_0000;
			div_rem <= 17'h0_0000;
			div_quot <= 24'h00_0000;
			div_cnt <= 5'h00;
			unbalance <= 24'h00_0000;
		end
		else
		begin
			case (div_state)
				rmf_pkg::DIV_IDLE:
				begin
					div_num <= 24'(negative_sequence_current * 24'd100);
					div_rem <= 17'h0_0000;
					div_cnt <= 5'h18;
					if (base_current != 16'h0000)
						div_state <= rmf_pkg::DIV_RUN;
				end
				rmf_pkg::DIV_RUN:
				begin
					div_num <= {div_num[22:0], 1'b0};
					if (!div_try[16])
					begin
						div_rem <= div_try;
						div_quot <= {div_quot[22:0], 1'b1};
					end
					else
					begin
						div_rem <= {div_rem[15:0], div_num[23]};
						div_quot <= {div_quot[22:0], 1'b0};
					end
					div_cnt <= div_cnt - 5'h01;
					if (div_cnt == 5'h01)
						div_state <= rmf_pkg::DIV_IDLE;
				end
				default:
					div_state <= rmf_pkg::DIV_IDLE;
			endcase
			if (div_state == rmf_pkg::DIV_IDLE && div_cnt == 5'h00)
			begin
				if (div_quot > rmf_pkg::UNBAL_MAX)
					unbalance <= rmf_pkg::UNBAL_MAX; // RULE_12
				else if (div_quot < rmf_pkg::UNBAL_MIN)
					unbalance <= 24'h00_0000; // RULE_12
				else
					unbalance <= div_quot;
			end
		end
	end

	// Disturbance recorder storage: two slots of 86 periods at 12 samples each.
	rmf_pkg::rmf_sample_t rec_mem [rmf_pkg::REC_SLOTS * DEPTH]; // RULE_15 RULE_16
	rmf_pkg::rmf_rec_state_t rec_state;
	logic wr_slot;
	logic [10:0] wr_idx;
	logic [10:0] post_left;
	logic [10:0] rec_start [rmf_pkg::REC_SLOTS];
	logic [31:0] rec_date [rmf_pkg::REC_SLOTS];
	logic [6:0] rec_pre [rmf_pkg::REC_SLOTS];
	logic [1:0] rec_kind_volt;
	logic [1:0] rec_valid;
	logic [10:0] pre_samples;
	rmf_pkg::rmf_sample_t new_sample;
	always_comb
	begin
		pre_samples = 11'(pretrig * 11'd12); // RULE_14
		new_sample.ana = ctrl[rmf_pkg::CTRL_REC_VOLTAGE] ? inst_voltage : inst_current; // RULE_17
		new_sample.din = digital_in;
		new_sample.trip = trip_output;
		new_sample.pickup = pickup;
	end

	// Sample memory write, one sample per tick into the active slot.
	always_ff @(posedge pclk)
	begin
		if (sample_tick)
			rec_mem[12'(wr_slot) * 12'(DEPTH) + 12'(wr_idx)] <= new_sample; // RULE_17
	end

	// Recorder control: circular pre-trigger fill, then a fixed count of post-trigger samples.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rec_state <= rmf_pkg::REC_FILL;
			wr_slot <= 1'b0;
			wr_idx <= 11'h000;
			post_left <= 11'h000;
			rec_valid <= 2'b00;
			rec_kind_volt <= 2'b00;
			for (int s = 0; s < rmf_pkg::REC_SLOTS; s++)
			begin
				rec_start[s] <= 11'h000;
				rec_date[s] <= 32'h0000_0000;
				rec_pre[s] <= 7'h00;
			end
		end
		else
		begin
			if (sample_tick)
				wr_idx <= (wr_idx == 11'(DEPTH - 1)) ? 11'h000 : wr_idx + 11'h001;
			case (rec_state)
				rmf_pkg::REC_FILL:
					if (rec_trigger)
					begin
						rec_state <= rmf_pkg::REC_POST;
						rec_valid[wr_slot] <= 1'b0; // RULE_16
						rec_start[wr_slot] <= (wr_idx >= pre_samples) ? wr_idx - pre_samples
							: 11'(wr_idx + 11'(DEPTH) - pre_samples); // RULE_14
						post_left <= 11'(11'(DEPTH) - pre_samples); // RULE_14
						rec_date[wr_slot] <= date_stamp; // RULE_18
						rec_pre[wr_slot] <= pretrig; // RULE_18
						rec_kind_volt[wr_slot] <= ctrl[rmf_pkg::CTRL_REC_VOLTAGE]; // RULE_18
					end
				rmf_pkg::REC_POST:
					if (sample_tick)
					begin
						post_left <= post_left - 11'h001;
						if (post_left == 11'h001)
						begin
							rec_state <= rmf_pkg::REC_FILL;
							rec_valid[wr_slot] <= 1'b1;
							wr_slot <= ~wr_slot; // RULE_16
						end
					end
				default:
					rec_state <= rmf_pkg::REC_FILL;
			endcase
		end
	end

	// Synchronous readout of the selected sample, relative to the record's first sample.
	rmf_pkg::rmf_sample_t rec_word;
	logic [11:0] rd_pos;
	always_comb
	begin
		rd_pos = 12'(rec_start[rec_sel_slot]) + 12'(rec_sel_index[10:0]);
		if (rd_pos >= 12'(DEPTH))
			rd_pos = rd_pos - 12'(DEPTH);
	end

	always_ff @(posedge pclk)
	begin
		rec_word <= rec_mem[12'(rec_sel_slot) * 12'(DEPTH) + rd_pos];
	end

	// APB slave: one wait state, so prdata and pready both come from flip-flops.
	logic apb_access;
	logic apb_commit;
	logic [31:0] rd_mux;
	logic rd_hit;
	assign apb_access = psel && penable && !pready;
	assign apb_commit = psel && penable && pready;
	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			rmf_pkg::OFS_CTRL: rd_mux = 32'(ctrl);
			rmf_pkg::OFS_RATED_V: rd_mux = 32'(rated_line_voltage);
			rmf_pkg::OFS_BASE_I: rd_mux = 32'(base_current);
			rmf_pkg::OFS_PRETRIG: rd_mux = 32'(pretrig);
			rmf_pkg::OFS_STATUS: rd_mux = 32'({wr_slot, rec_valid, rec_state, (trip_timer != 32'h0000_0000),
				maintenance_alarm, freq_valid});
			rmf_pkg::OFS_FREQ: rd_mux = 32'(freq_value);
			rmf_pkg::OFS_RESID_V: rd_mux = residual_voltage;
			rmf_pkg::OFS_POSSEQ_V: rd_mux = 32'(positive_sequence_voltage);
			rmf_pkg::OFS_UNBAL: rd_mux = 32'(unbalance);
			rmf_pkg::OFS_TRIP_I1: rd_mux = 32'(trip_current_phase1);
			rmf_pkg::OFS_TRIP_I2: rd_mux = 32'(trip_current_phase2);
			rmf_pkg::OFS_TRIP_I3: rd_mux = 32'(trip_current_phase3);
			rmf_pkg::OFS_TRIP_I0: rd_mux = 32'(trip_current_residual);
			rmf_pkg::OFS_TEMP_FAULT: rd_mux = {16'h0000, temp_short, temp_open};
			rmf_pkg::OFS_REC_SEL: rd_mux = {15'h0000, rec_sel_slot, rec_sel_index};
			rmf_pkg::OFS_REC_ANA01: rd_mux = {rec_word.ana[1], rec_word.ana[0]};
			rmf_pkg::OFS_REC_ANA23: rd_mux = {rec_word.ana[3], rec_word.ana[2]};
			rmf_pkg::OFS_REC_DIG: rd_mux = {20'h0_0000, rec_word.pickup, rec_word.trip, rec_word.din};
			rmf_pkg::OFS_REC_DATE: rd_mux = rec_date[rec_sel_slot];
			rmf_pkg::OFS_REC_INFO: rd_mux = {23'h00_0000, rec_valid[rec_sel_slot], rec_kind_volt[rec_sel_slot],
				rec_pre[rec_sel_slot]};
			default:
			begin
				if (paddr >= rmf_pkg::OFS_TEMP01 && paddr < 8'(rmf_pkg::OFS_TEMP01 + 8'h10) && paddr[1:0] == 2'b00)
					rd_mux = {temp_display[{paddr[3:2], 1'b1}], temp_display[{paddr[3:2], 1'b0}]};
				else
					rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= apb_access;
			pslverr <= apb_access && !rd_hit;
			prdata <= (apb_access && !pwrite && rd_hit) ? rd_mux : 32'h0000_0000;
		end
	end

	// Register writes take effect at the completing edge only.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= rmf_pkg::CTRL_RESET;
			rated_line_voltage <= rmf_pkg::RATED_V_RESET;
			base_current <= rmf_pkg::BASE_I_RESET;
			pretrig <= rmf_pkg::PRETRIG_RESET;
			rec_sel_index <= 16'h0000;
			rec_sel_slot <= 1'b0;
		end
		else if (apb_commit && pwrite && !pslverr)
		begin
			case (paddr)
				rmf_pkg::OFS_CTRL: ctrl <= pwdata[4:0];
				rmf_pkg::OFS_RATED_V: rated_line_voltage <= pwdata[15:0]; // RULE_19
				rmf_pkg::OFS_BASE_I: base_current <= pwdata[15:0];
				rmf_pkg::OFS_PRETRIG: pretrig <= (pwdata[6:0] > 7'(rmf_pkg::REC_PERIODS)) ? 7'(rmf_pkg::REC_PERIODS)
					: pwdata[6:0];
				rmf_pkg::OFS_REC_SEL:
				begin
					rec_sel_index <= (pwdata[15:0] >= 16'(DEPTH)) ? 16'(DEPTH - 1) : pwdata[15:0];
					rec_sel_slot <= pwdata[16];
				end
				default:
				begin
				end
			endcase
		end
	end
endmodule // rmf_top

// *** dv/rmf_checker.sv ***
// Port checker for the metering and fault recorder block.
`timescale 1ns/1ps
module rmf_checker (
	// Clock, reset and bus.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Metering.
	input wire logic [15:0] freq_measured,
	input wire logic signed [15:0] temp_in [rmf_pkg::TEMP_CHANNELS],
	input wire logic freq_valid,
	input wire logic maintenance_alarm
);
	// Every check runs on the bus clock; reset cancels any check in flight.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
	idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
	unmapped_err_a: assert property (pready && paddr > 8'h5C |-> pslverr) else $error("no pslverr");
	freq_window_a: assert property (freq_valid |-> $past(freq_measured) >= rmf_pkg::F50_LOW) else $error("freq low");
	freq_low_off_a: assert property ((freq_measured < rmf_pkg::F50_LOW) [*3] |-> !freq_valid) else $error("freq valid");
	open_alarm_a: assert property ((temp_in[0] > rmf_pkg::TEMP_OPEN_LIMIT) [*3] |-> maintenance_alarm) else $error("open");
	short_alarm_a: assert property ((temp_in[3] < rmf_pkg::TEMP_SHORT_LIMIT) [*3] |-> maintenance_alarm) else $error("short");
	cover property (pready && pslverr);
	cover property ($rose(maintenance_alarm));
	cover property ($fell(freq_valid));
endmodule // rmf_checker
bind rmf_top rmf_checker chk_u (.*);

// *** dv/rmf_sensor_model.sv ***
// Sensor front end model: phasors, magnitudes, temperatures and sample ticks.
`timescale 1ns/1ps
module rmf_sensor_model (
	// Clock.
	input wire logic pclk,
	// Sensor channels.
	output logic sample_tick,
	output rmf_pkg::rmf_phasor_t volt_phase [3],
	output rmf_pkg::rmf_phasor_t curr_phase [3],
	output rmf_pkg::rmf_phasor_t residual_voltage_ext,
	output logic [15:0] line_voltage_2_1,
	output logic [15:0] curr_rms [3],
	output logic [15:0] residual_current,
	output logic [15:0] freq_measured,
	output logic signed [15:0] temp_in [rmf_pkg::TEMP_CHANNELS],
	output logic [3:0][15:0] inst_current,
	output logic [3:0][15:0] inst_voltage
);
	logic [1:0] div;
	// A healthy feed at power up; the bench steers levels from here.
	initial
	begin
		div = 2'h0;
		sample_tick = 1'b0;
		volt_phase = '{'{16'sh0064, 16'sh000A}, '{16'sh00C8, 16'sh0014}, '{16'sh012C, 16'sh001E}};
		curr_phase = '{default: '0};
		residual_voltage_ext = {16'sh0007, 16'sh0009};
		line_voltage_2_1 = 16'h2710;
		curr_rms = '{16'h0064, 16'h00C8, 16'h012C};
		residual_current = 16'h0032;
		freq_measured = 16'h1388;
		temp_in = '{default: 16'sh0019};
	end
	// A tick every fourth clock keeps records short.
	always @(posedge pclk)
	begin
		div <= div + 2'h1;
		sample_tick <= (div == 2'h3);
		inst_current <= {4{div, 14'h0155}};
		inst_voltage <= ~{4{div, 14'h0155}};
	end
endmodule // rmf_sensor_model

// *** dv/relay_metering_and_fault_recorder_test.sv ***
// Self-checking bench for the metering and fault recorder block.
`timescale 1ns/1ps
module relay_metering_and_fault_recorder_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_tick, pickup, trip_output, rec_trigger, e;
	logic freq_valid, maintenance_alarm;
	logic [7:0] paddr;
	logic [9:0] digital_in;
	logic [31:0] pwdata, prdata, date_stamp, q;
	rmf_pkg::rmf_phasor_t volt_phase [3], curr_phase [3], residual_voltage_ext;
	logic [15:0] line_voltage_2_1, residual_current, freq_measured, curr_rms [3];
	logic signed [15:0] temp_in [rmf_pkg::TEMP_CHANNELS];
	logic [3:0][15:0] inst_current, inst_voltage;
	int err_total, comparisons, cyc;
	rmf_top #(.TRIP_WINDOW_CYCLES(50)) dut_u (.*);
	rmf_sensor_model sens_u (.*);
	// A 50 ns clock.
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the idle lead-in lets metering settle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		repeat (4) @(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1)
			@(negedge pclk);
		q = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hang counts as a mismatch.
	always @(posedge pclk)
		if (++cyc == 20000)
		begin
			err_total++;
			stop_test();
		end
	// Main sequence.
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, pickup, trip_output, rec_trigger} = '0;
		digital_in = 10'h155;
		date_stamp = 32'h1234_5678;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(rmf_pkg::OFS_RATED_V, 32'h0000_2710);
		rd(rmf_pkg::OFS_PRETRIG, 32'h0000_0024);
		rd(8'h60, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		apb(1'b1, rmf_pkg::OFS_PRETRIG, 32'h0000_0064);
		rd(rmf_pkg::OFS_PRETRIG, 32'h0000_0056);
		rd(rmf_pkg::OFS_RESID_V, 32'h0258_003C);
		apb(1'b1, rmf_pkg::OFS_CTRL, 32'h0000_0001);
		rd(rmf_pkg::OFS_RESID_V, 32'h0007_0009);
		rd(rmf_pkg::OFS_FREQ, 32'h0000_1388);
		sens_u.freq_measured <= 16'h1193;
		rd(rmf_pkg::OFS_FREQ, 32'h0000_0000);
		chk({31'h0, freq_valid}, 32'h0000_0000);
		sens_u.freq_measured <= 16'h15E0;
		apb(1'b1, rmf_pkg::OFS_CTRL, 32'h0000_0004);
		rd(rmf_pkg::OFS_FREQ, 32'h0000_15E0);
		sens_u.line_voltage_2_1 <= 16'h0F9F;
		rd(rmf_pkg::OFS_FREQ, 32'h0000_0000);
		sens_u.temp_in[0] <= 16'sh00CE;
		sens_u.temp_in[3] <= 16'shFFDC;
		rd(rmf_pkg::OFS_TEMP_FAULT, 32'h0000_0801);
		rd(rmf_pkg::OFS_TEMP01, 32'h0019_8000);
		chk({31'h0, maintenance_alarm}, 32'h0000_0001);
		sens_u.temp_in[0] <= 16'sh00CD;
		sens_u.temp_in[3] <= 16'shFFDD;
		rd(rmf_pkg::OFS_TEMP_FAULT, 32'h0000_0000);
		chk({31'h0, maintenance_alarm}, 32'h0000_0000);
		trip_output <= 1'b1;
		repeat (5) @(posedge pclk);
		sens_u.curr_rms[1] <= 16'h0400;
		repeat (5) @(posedge pclk);
		sens_u.curr_rms[1] <= 16'h0010;
		repeat (60) @(posedge pclk);
		sens_u.curr_rms[0] <= 16'h0384;
		rd(rmf_pkg::OFS_TRIP_I2, 32'h0000_0400);
		rd(rmf_pkg::OFS_TRIP_I1, 32'h0000_0064);
		trip_output <= 1'b0;
		apb(1'b1, rmf_pkg::OFS_PRETRIG, 32'h0000_0024);
		trip_output <= 1'b1;
		rd(rmf_pkg::OFS_TRIP_I2, 32'h0000_0010);
		for (int k = 0; k < 3; k++)
		begin
			rec_trigger <= 1'b1;
			@(posedge pclk);
			rec_trigger <= 1'b0;
			date_stamp <= date_stamp + 32'h0000_0001;
			repeat (k < 2 ? 2600 : 10) @(posedge pclk);
			apb(1'b0, rmf_pkg::OFS_STATUS, 32'h0000_0000);
			chk({29'h0, q[6:4]}, k == 0 ? 32'h0000_0005 : k == 1 ? 32'h0000_0003 : 32'h0000_0002);
		end
		apb(1'b1, rmf_pkg::OFS_REC_SEL, 32'h0001_0000);
		rd(rmf_pkg::OFS_REC_DATE, 32'h1234_5679);
		rd(rmf_pkg::OFS_REC_INFO, 32'h0000_0124);
		stop_test();
	end
endmodule // relay_metering_and_fault_recorder_test
